/* sfs_regs.svh */
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// Register byte offsets
`define SFS_OFF_STAT      12'h000
`define SFS_OFF_QSTAT     12'h004
`define SFS_OFF_CHCTL     12'h008
`define SFS_OFF_OUTCTL    12'h00C
`define SFS_OFF_MODE      12'h010
`define SFS_OFF_IRQ_STAT  12'h014
`define SFS_OFF_IRQ_MASK  12'h018
`define SFS_OFF_OUTSTAT   12'h01C

// Field positions
`define SFS_BIT_DSF       0
`define SFS_BIT_LOW       1
`define SFS_BIT_HIGH      2
`define SFS_BIT_PUMP      3
`define SFS_BIT_LDUMP     4
`define SFS_BIT_FAIL      0

// Timing in ns and auto-restart in ms
`define SFS_CLK_NS        10
`define SFS_SUPPLY_DGL_NS 3500
`define SFS_PUMP_DGL_NS   4000
`define SFS_RESTART_MS    64

// AXI responses
`define SFS_RESP_OKAY     2'h0
`define SFS_RESP_SLVERR   2'h2

`endif

/* sfs_pkg.sv */
package sfs_pkg;
   typedef enum logic [1:0] {
      SFS_RUN,
      SFS_SHUT,
      SFS_WAIT_RESTART
   } sfs_state_t;
   typedef logic [4:0] sfs_chan_t;
endpackage

/* sfs_flag_if.sv */
`timescale 1ns/100ps
interface sfs_flag_if;
   logic raw;
   logic fault;
   logic rd_clr;
   logic flag;
   modport filt (input raw, input rd_clr, output fault, output flag);
   modport user (output raw, output rd_clr, input fault, input flag);
endinterface

/* sfs_deglitch.sv */
`timescale 1ns/100ps
`include "sfs_regs.svh"
// Deglitch filter plus read-to-clear latched flag
module sfs_deglitch #(
   parameter int DGL_CYC = 350
) (
   input  wire logic clk,
   input  wire logic rst,
   sfs_flag_if.filt  f
);
   import sfs_pkg::*;
   localparam int CW = $clog2(DGL_CYC + 1);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          fault_q;
   logic          flag_q;
   wire           done = (cnt_q == CW'(DGL_CYC));
   assign cnt_d   = !f.raw ? '0 : (done ? cnt_q : cnt_q + CW'(1));
   assign f.fault = fault_q;
   assign f.flag  = flag_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q   <= '0;
         fault_q <= 1'b0;
         flag_q  <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         fault_q <= f.raw & done;
         // Set wins over read clear; a still-present fault keeps the flag
         if (f.raw & done)
            flag_q <= 1'b1;
         else if (f.rd_clr)
            flag_q <= 1'b0;
      end
   end
endmodule

/* sfs_top.sv */
`timescale 1ns/100ps
`include "sfs_regs.svh"
// Function
// - Supply low held for deglitch time switches all five outputs off.
// - Deglitched supply low sets fault summary and supply low flag.
// - Normal mode: outputs stay off until controller rewrites on bits.
// - Supply low flag clears only after condition gone and status read.
// - Fail mode restarts outputs automatically after supply low shutdown.
// - Auto-restart interval is 64 ms nominal.
// - Supply high sets fault summary and supply high flag.
// - Supply high flag clears only after condition gone and status read.
// - Load dump keeps outputs off.
// - Turn-on requests wait until pump settles, then execute.
// - Pump fault held for its deglitch time disables all outputs.
// - Deglitched pump fault sets fault summary and pump fault flag.
// - Requests during pump fault kept; apply with inrush window restarted.
// - Pump fault flag clears only after condition gone and quick read.
module sfs_top #(
   parameter int NCH        = 5,
   parameter int RESTART_CYC = `SFS_RESTART_MS * 1000000 / `SFS_CLK_NS
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 supply_low_in,
   input  wire logic                 supply_high_in,
   input  wire logic                 load_dump_in,
   input  wire logic                 pump_bad_in,
   input  wire logic                 pump_settled_in,
   output logic      [NCH-1:0]       out_en,
   output logic      [NCH-1:0]       inrush_current_window,
   output logic                      irq,
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic      [1:0]           s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic      [31:0]          s_axi_rdata,
   output logic      [1:0]           s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);
   import sfs_pkg::*;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PS     = `SFS_CLK_NS * 1000;
   localparam int SUP_DGL    = (`SFS_SUPPLY_DGL_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int PUMP_DGL   = (`SFS_PUMP_DGL_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RCW        = $clog2(RESTART_CYC + 1);

   // ------------------------------------------------------------
   // Fault filters
   // ------------------------------------------------------------
   sfs_flag_if low_f ();
   sfs_flag_if high_f ();
   sfs_flag_if pump_f ();

   logic stat_rd;
   logic qstat_rd;

   assign low_f.raw     = supply_low_in;
   assign high_f.raw    = supply_high_in;
   assign pump_f.raw    = pump_bad_in;
   assign low_f.rd_clr  = stat_rd;
   assign high_f.rd_clr = stat_rd;
   assign pump_f.rd_clr = qstat_rd;

   sfs_deglitch #(.DGL_CYC(SUP_DGL)) u_low (
      .clk (clk),
      .rst (rst),
      .f   (low_f)
   );
   sfs_deglitch #(.DGL_CYC(SUP_DGL)) u_high (
      .clk (clk),
      .rst (rst),
      .f   (high_f)
   );
   sfs_deglitch #(.DGL_CYC(PUMP_DGL)) u_pump (
      .clk (clk),
      .rst (rst),
      .f   (pump_f)
   );

   wire device_fault_summary_flag = low_f.flag | high_f.flag | pump_f.flag;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [NCH-1:0] req_q;
   logic           fail_q;
   logic [4:0]     ists_q;
   logic [4:0]     imsk_q;
   sfs_state_t     st_q;
   logic [RCW-1:0] rcnt_q;
   logic [NCH-1:0] on_q;

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic        aw_h_q;
   logic        w_h_q;
   logic [11:0] awa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;

   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire wr_go   = aw_h_q & w_h_q & ~s_axi_bvalid;
   wire rd_take = s_axi_arvalid & s_axi_arready;

   wire wr_chctl  = wr_go & (awa_q == `SFS_OFF_CHCTL);
   wire wr_outctl = wr_go & (awa_q == `SFS_OFF_OUTCTL);
   wire wr_mode   = wr_go & (awa_q == `SFS_OFF_MODE);
   wire wr_ists   = wr_go & (awa_q == `SFS_OFF_IRQ_STAT);
   wire wr_imsk   = wr_go & (awa_q == `SFS_OFF_IRQ_MASK);
   wire wr_hit    = wr_chctl | wr_outctl | wr_mode | wr_ists | wr_imsk;
   wire wr_on     = (wr_chctl | wr_outctl) & ws_q[0];

   assign stat_rd  = rd_take & (s_axi_araddr == `SFS_OFF_STAT);
   assign qstat_rd = rd_take & (s_axi_araddr == `SFS_OFF_QSTAT);

   wire [31:0] stat_v  = {27'h0, load_dump_in, pump_f.flag, high_f.flag,
                          low_f.flag, device_fault_summary_flag};
   wire [31:0] qstat_v = {28'h0, pump_f.flag, 2'h0, device_fault_summary_flag};
   logic [31:0] rd_v;
   logic        rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `SFS_OFF_STAT:     rd_v = stat_v;
         `SFS_OFF_QSTAT:    rd_v = qstat_v;
         `SFS_OFF_CHCTL:    rd_v = {{(32-NCH){1'b0}}, req_q};
         `SFS_OFF_OUTCTL:   rd_v = {{(32-NCH){1'b0}}, req_q};
         `SFS_OFF_MODE:     rd_v = {31'h0, fail_q};
         `SFS_OFF_IRQ_STAT: rd_v = {27'h0, ists_q};
         `SFS_OFF_IRQ_MASK: rd_v = {27'h0, imsk_q};
         `SFS_OFF_OUTSTAT:  rd_v = {{(32-NCH){1'b0}}, on_q};
         default: begin
            rd_v  = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_h_q        <= 1'b0;
         w_h_q         <= 1'b0;
         awa_q         <= 12'h000;
         wd_q          <= 32'h0;
         ws_q          <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SFS_RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_h_q & ~aw_take;
         s_axi_wready  <= ~w_h_q & ~w_take;
         if (aw_take) begin
            aw_h_q <= 1'b1;
            awa_q  <= s_axi_awaddr;
         end
         if (w_take) begin
            w_h_q <= 1'b1;
            wd_q  <= s_axi_wdata;
            ws_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_h_q       <= 1'b0;
            w_h_q        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `SFS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~rd_take;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_v;
            s_axi_rresp  <= rd_ok ? `SFS_RESP_OKAY : `SFS_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Control and interrupt registers
   // ------------------------------------------------------------
   wire [4:0] ev = {load_dump_in, pump_f.fault, high_f.fault,
                    low_f.fault, low_f.fault | high_f.fault | pump_f.fault};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_q  <= '0;
         fail_q <= 1'b0;
         ists_q <= 5'h00;
         imsk_q <= 5'h00;
         irq    <= 1'b0;
      end else begin
         // Requests are kept across pump faults and power up
         // Byte 0 strobe gates the on bits
         if (wr_on)
            req_q <= wd_q[NCH-1:0];
         else if (st_q == SFS_SHUT && !fail_q)
            req_q <= '0;
         if (wr_mode)
            fail_q <= wd_q[`SFS_BIT_FAIL];
         if (wr_imsk)
            imsk_q <= wd_q[4:0];
         // Set wins over write-one-to-clear
         ists_q <= (ists_q & ~(wr_ists ? wd_q[4:0] : 5'h00)) | ev;
         irq    <= |(ists_q & imsk_q);
      end
   end

   // ------------------------------------------------------------
   // Shutdown and restart sequencing
   // ------------------------------------------------------------
   wire uv_shut   = low_f.fault;
   wire restart_d = (rcnt_q == RCW'(RESTART_CYC));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q   <= SFS_RUN;
         rcnt_q <= '0;
      end else begin
         case (st_q)
            SFS_RUN: begin
               if (uv_shut)
                  st_q <= SFS_SHUT;
            end
            SFS_SHUT: begin
               rcnt_q <= '0;
               if (!supply_low_in)
                  st_q <= fail_q ? SFS_WAIT_RESTART : SFS_RUN;
            end
            SFS_WAIT_RESTART: begin
               rcnt_q <= rcnt_q + RCW'(1);
               if (uv_shut)
                  st_q <= SFS_SHUT;
               else if (restart_d)
                  st_q <= SFS_RUN;
            end
            default: st_q <= SFS_RUN;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Output drive
   // ------------------------------------------------------------
   wire block = uv_shut | pump_f.fault | load_dump_in
                | ~pump_settled_in | (st_q != SFS_RUN);
   wire [NCH-1:0] on_d = block ? '0 : req_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         on_q                  <= '0;
         out_en                <= '0;
         inrush_current_window <= '0;
      end else begin
         on_q                  <= on_d;
         out_en                <= on_d;
         inrush_current_window <= on_d & ~on_q;
      end
   end
endmodule

/* sfs_props.sv */
`timescale 1ns/100ps
module sfs_props #(
   parameter int NCH      = 5,
   parameter int LOW_LIM  = 352,
   parameter int PUMP_LIM = 402
) (
   input wire logic           clk,
   input wire logic           rst,
   input wire logic           supply_low_in,
   input wire logic           load_dump_in,
   input wire logic           pump_bad_in,
   input wire logic           pump_settled_in,
   input wire logic [NCH-1:0] out_en,
   input wire logic [NCH-1:0] inrush_current_window,
   input wire logic           s_axi_bvalid,
   input wire logic           s_axi_bready,
   input wire logic           s_axi_arvalid,
   input wire logic           s_axi_arready,
   input wire logic           s_axi_rvalid,
   input wire logic           s_axi_rready,
   input wire logic [31:0]    s_axi_rdata
);
   // Run lengths saturate so a long fault never wraps back below the limit
   // Limits are the deglitch length plus the fault and output register stages
   logic [9:0] low_q;
   logic [9:0] pump_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_q  <= 10'h000;
         pump_q <= 10'h000;
      end else begin
         low_q  <= supply_low_in ? low_q + 10'(~&low_q) : 10'h000;
         pump_q <= pump_bad_in ? pump_q + 10'(~&pump_q) : 10'h000;
      end
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_rd_held;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   property p_low_off;
      (low_q >= 10'(LOW_LIM)) |-> (out_en == '0);
   endproperty
   property p_pump_off;
      (pump_q >= 10'(PUMP_LIM)) |-> (out_en == '0);
   endproperty
   property p_dump_off;
      load_dump_in [*4] |-> (out_en == '0);
   endproperty
   property p_settle;
      $rose(|out_en) |-> $past(pump_settled_in);
   endproperty
   property p_inrush;
      (inrush_current_window != '0) |->
         ((out_en & inrush_current_window) == inrush_current_window)
         && ((inrush_current_window & $past(out_en)) == '0);
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_r_hold;
      s_rd_held |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_r_answer;
      s_rd_taken |=> s_axi_rvalid;
   endproperty
   a_low_off: assert property (p_low_off)
      else $error("outputs on under supply low");
   a_pump_off: assert property (p_pump_off)
      else $error("outputs on under pump fault");
   a_dump_off: assert property (p_dump_off)
      else $error("outputs on under load dump");
   a_settle: assert property (p_settle)
      else $error("output on before pump settled");
   a_inrush: assert property (p_inrush)
      else $error("inrush window without turn-on");
   a_b_hold: assert property (p_b_hold)
      else $error("bvalid dropped early");
   a_r_hold: assert property (p_r_hold)
      else $error("read answer not held");
   a_r_answer: assert property (p_r_answer)
      else $error("read not answered");
endmodule

bind sfs_top sfs_props #(
   .NCH      (NCH),
   .LOW_LIM  (SUP_DGL + 2),
   .PUMP_LIM (PUMP_DGL + 2)
) i_sfs_props (
   .clk, .rst, .supply_low_in, .load_dump_in, .pump_bad_in, .pump_settled_in, .out_en,
   .inrush_current_window, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

/* sfs_ctl_model.sv */
`timescale 1ns/100ps
module sfs_ctl_model (
   input  wire logic        clk,
   output logic      [11:0] s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic      [31:0] s_axi_wdata,
   output logic      [3:0]  s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic      [11:0] s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   logic hang = 1'b0;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   // ---------------------------------------------
   // Bus cycles; released payload is inverted so stale data never matches
   // ---------------------------------------------
   task automatic write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      hang = hang | (n == 100);
   endtask
   task automatic read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~a;
         end
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      hang = hang | (n == 100);
   endtask
endmodule

/* tb.sv */
`timescale 1ns/100ps
`include "sfs_regs.svh"
module tb;
   localparam int         RST_CYC = 50;
   localparam logic [1:0] OK      = `SFS_RESP_OKAY;
   localparam logic [1:0] ERR     = `SFS_RESP_SLVERR;
   logic        clk = 1'b0, rst = 1'b1, pump_settled_in = 1'b0, seen_clr = 1'b0;
   logic [3:0]  flt = 4'h0;
   wire         supply_low_in = flt[0], supply_high_in = flt[1];
   wire         load_dump_in = flt[2], pump_bad_in = flt[3];
   logic [4:0]  out_en, inrush_current_window, req, seen_q = 5'h00;
   logic        irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          miscompares = 0, cmp_count = 0, seed = 9714, k;
   sfs_top #(.RESTART_CYC(RST_CYC)) i_sfs_top (
      .clk, .rst, .supply_low_in, .supply_high_in, .load_dump_in, .pump_bad_in,
      .pump_settled_in, .out_en, .inrush_current_window, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   sfs_ctl_model i_sfs_ctl_model (
      .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial forever #5 clk = ~clk;
   always @(posedge clk) seen_q <= seen_clr ? 5'h00 : (seen_q | inrush_current_window);
   // ---------------------------------------------
   // Checking helpers
   // ---------------------------------------------
   task automatic tally_and_finish();
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic guard();
      if (i_sfs_ctl_model.hang) begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      i_sfs_ctl_model.write(a, d, rsp);
      guard();
      check("bresp", 32'(rsp), 32'(er));
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      i_sfs_ctl_model.read(a, rd_v, rsp);
      guard();
      check("rdata", rd_v, ed);
      check("rresp", 32'(rsp), 32'(er));
   endtask
   task automatic set_in(input int b, input logic v);
      @(posedge clk);
      flt[b] <= v;
   endtask
   task automatic wait_out(input logic [4:0] e);
      for (k = 0; k < 200 && out_en !== e; k++) @(negedge clk);
      if (k == 200) begin
         miscompares++;
         tally_and_finish();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(`SFS_OFF_STAT, 32'h0, OK);
      wr(`SFS_OFF_CHCTL, 32'h1F, OK);
      cyc(10);
      check("out_en", 32'(out_en), 32'h0);
      @(posedge clk) pump_settled_in <= 1'b1;
      wait_out(5'h1F);
      cyc(2);
      check("inrush", 32'(seen_q), 32'h1F);
      k = $unsigned($random(seed)) % 300;
      set_in(0, 1'b1);
      repeat (20 + k) @(posedge clk);
      flt[0] <= 1'b0;
      cyc(5);
      check("out_en", 32'(out_en), 32'h1F);
      rd(`SFS_OFF_STAT, 32'h0, OK);
      set_in(0, 1'b1);
      cyc(360);
      check("out_en", 32'(out_en), 32'h0);
      rd(`SFS_OFF_STAT, 32'h3, OK);
      rd(`SFS_OFF_STAT, 32'h3, OK);
      set_in(0, 1'b0);
      cyc(20);
      check("out_en", 32'(out_en), 32'h0);
      rd(`SFS_OFF_STAT, 32'h3, OK);
      rd(`SFS_OFF_STAT, 32'h0, OK);
      req = 5'($random(seed)) | 5'h01;
      wr(`SFS_OFF_OUTCTL, {27'h0, req}, OK);
      wait_out(req);
      check("irq", 32'(irq), 32'h0);
      wr(`SFS_OFF_IRQ_MASK, 32'h2, OK);
      cyc(3);
      check("irq", 32'(irq), 32'h1);
      rd(`SFS_OFF_IRQ_STAT, 32'h3, OK);
      wr(`SFS_OFF_IRQ_STAT, 32'h1F, OK);
      cyc(3);
      check("irq", 32'(irq), 32'h0);
      set_in(1, 1'b1);
      cyc(360);
      rd(`SFS_OFF_STAT, 32'h5, OK);
      set_in(1, 1'b0);
      rd(`SFS_OFF_STAT, 32'h5, OK);
      rd(`SFS_OFF_STAT, 32'h0, OK);
      set_in(3, 1'b1);
      cyc(410);
      check("out_en", 32'(out_en), 32'h0);
      wr(`SFS_OFF_CHCTL, 32'h1F, OK);
      cyc(5);
      check("out_en", 32'(out_en), 32'h0);
      rd(`SFS_OFF_QSTAT, 32'h9, OK);
      seen_clr <= 1'b1;
      @(posedge clk) seen_clr <= 1'b0;
      set_in(3, 1'b0);
      wait_out(5'h1F);
      cyc(2);
      check("inrush", 32'(seen_q), 32'h1F);
      rd(`SFS_OFF_QSTAT, 32'h9, OK);
      rd(`SFS_OFF_QSTAT, 32'h0, OK);
      wr(`SFS_OFF_MODE, 32'h1, OK);
      set_in(0, 1'b1);
      cyc(360);
      check("out_en", 32'(out_en), 32'h0);
      set_in(0, 1'b0);
      wait_out(5'h1F);
      check("restart", 32'(k >= RST_CYC - 1 && k <= RST_CYC + 8), 32'h1);
      set_in(2, 1'b1);
      cyc(6);
      check("out_en", 32'(out_en), 32'h0);
      set_in(2, 1'b0);
      rd(12'h100, 32'h0, ERR);
      wr(12'h100, 32'h1, ERR);
      wr(`SFS_OFF_STAT, 32'h1, ERR);
      tally_and_finish();
   end
endmodule
